// [sfb_params.svh]
`ifndef SFB_PARAMS_SVH
`define SFB_PARAMS_SVH

// ==========================================================================
// Register map (byte addresses, one 32-bit word each)
// ==========================================================================
`define SFB_CTRL_OFS 12'h000
`define SFB_STAT_OFS 12'h004
`define SFB_EVT_OFS 12'h008

// Control register fields and reset value
`define SFB_CTRL_QLE_BIT 0
`define SFB_CTRL_SL0_BIT 1
`define SFB_CTRL_SL1_BIT 2
`define SFB_CTRL_RST 3'h0

// Status register fields
`define SFB_STAT_BUSY_BIT 0
`define SFB_STAT_WUL_BIT 1
`define SFB_STAT_FLM_BIT 2
`define SFB_STAT_PD_BIT 3
`define SFB_STAT_PUW_BIT 4
`define SFB_STAT_ARM_BIT 5
`define SFB_STAT_HOLD_BIT 6
`define SFB_STAT_OP_LSB 8

// Event register fields
`define SFB_EVT_REJ_BIT 0

// ==========================================================================
// Instruction codes
// ==========================================================================
`define SFB_OP_WREN 8'h06
`define SFB_OP_WRDI 8'h04
`define SFB_OP_RDSR 8'h05
`define SFB_OP_WRSR 8'h01
`define SFB_OP_READ 8'h03
`define SFB_OP_FREAD 8'h0B
`define SFB_OP_PP 8'h02
`define SFB_OP_QPP 8'h32
`define SFB_OP_SE 8'h20
`define SFB_OP_BE32 8'h52
`define SFB_OP_BE64 8'hD8
`define SFB_OP_CE 8'hC7
`define SFB_OP_DOUT 8'h3B
`define SFB_OP_DIO 8'hBB
`define SFB_OP_QOUT 8'h6B
`define SFB_OP_QIO 8'hEB
`define SFB_OP_QWRD 8'hE7
`define SFB_OP_QOCT 8'hE3
`define SFB_OP_FLM_ON 8'h38
`define SFB_OP_FLM_OFF 8'hFF
`define SFB_OP_SWRST 8'h99
`define SFB_OP_PDN 8'hB9
`define SFB_OP_RPD 8'hAB

// ==========================================================================
// Timing
// ==========================================================================
`define SFB_CLK_NS 5
`define SFB_PUW_NS 10000
`define SFB_PUW_CYC ((`SFB_PUW_NS + `SFB_CLK_NS - 1) / `SFB_CLK_NS)

`endif

// [sfb_pkg.sv]
// ==========================================================================
// Shared types
// ==========================================================================
package sfb_pkg;

    // Bus pins as seen by the device
    typedef struct packed {
        logic clk;
        logic csn;
        logic [3:0] lane;
    } sfb_pins_t;

    // Instruction frame progress
    typedef enum logic [1:0] {
        FR_IDLE,
        FR_CMD,
        FR_SEND,
        FR_SKIP
    } sfb_frame_t;

endpackage

// [sfb_front_end.sv]
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "sfb_params.svh"

module sfb_front_end #(
    parameter int PUW_CYC = `SFB_PUW_CYC,
    parameter int AW = 12
) (
    input wire logic sys_clk, // System clock
    input wire logic resetn, // Power-on reset, active low
    input wire logic bus_clk, // Serial bus clock pin
    input wire logic bus_csn, // Select pin, active low
    input wire logic [3:0] lane_in, // Lane pin levels
    output logic [3:0] lane_out, // Lane drive values
    output logic [3:0] lane_oe, // Lane drive enables
    input wire logic [7:0] rd_byte, // Array read data
    input wire logic op_done, // Array operation finished
    output logic op_start, // Array operation start pulse
    output logic [7:0] op_code, // Opcode of started operation
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [AW-1:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr // APB error
);

    // ======================================================================
    // Pin synchronisers and edge detection
    // ======================================================================
    sfb_pkg::sfb_pins_t pins;
    sfb_pkg::sfb_pins_t pin_s1;
    sfb_pkg::sfb_pins_t pin_s2;
    sfb_pkg::sfb_pins_t pin_s3;

    assign pins = '{clk: bus_clk, csn: bus_csn, lane: lane_in};

    // Two-stage sync plus one history stage for edges
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1 <= '{clk: 1'b0, csn: 1'b1, lane: 4'hF};
            pin_s2 <= '{clk: 1'b0, csn: 1'b1, lane: 4'hF};
            pin_s3 <= '{clk: 1'b0, csn: 1'b1, lane: 4'hF};
        end else begin
            pin_s1 <= pins;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic selected;

    // Both clock modes work since only edges inside a selection matter
    assign sclk_rise = pin_s2.clk & ~pin_s3.clk;
    assign sclk_fall = ~pin_s2.clk & pin_s3.clk;
    assign cs_fall = ~pin_s2.csn & pin_s3.csn;
    assign selected = ~pin_s2.csn;

    // ======================================================================
    // State declarations
    // ======================================================================
    logic [2:0] ctrl;
    logic quad_lane_enable;
    logic lock0;
    logic lock1;
    logic armed;
    logic [15:0] puw_cnt;
    logic puw_lock;
    logic held;
    logic four_lane;
    logic pdown;
    logic wul;
    logic busy;
    logic rej_evt;
    logic [7:0] last_op;
    sfb_pkg::sfb_frame_t frame;
    logic [3:0] bit_cnt;
    logic [7:0] cmd_sh;
    logic [2:0] width;
    logic [7:0] tx_sh;
    logic [3:0] tx_left;
    logic tx_started;
    logic tx_status;

    assign quad_lane_enable = ctrl[`SFB_CTRL_QLE_BIT];
    assign lock0 = ctrl[`SFB_CTRL_SL0_BIT];
    assign lock1 = ctrl[`SFB_CTRL_SL1_BIT];
    assign puw_lock = (puw_cnt != 16'h0000);

    // ======================================================================
    // Power-up arming and write delay
    // ======================================================================
    // Frames start only on a select fall, which also arms the device
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            armed <= 1'b0;
        end else if (cs_fall) begin
            armed <= 1'b1;
        end
    end

    // Count down the delay after reset release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            puw_cnt <= 16'(PUW_CYC);
        end else if (puw_cnt != 16'h0000) begin
            puw_cnt <= puw_cnt - 16'h0001;
        end
    end

    // ======================================================================
    // Pause handling
    // ======================================================================
    logic hold_allow;
    logic hold_req;

    // Pause pin exists only without quad enable and outside four-lane work
    assign hold_allow = selected & ~quad_lane_enable & ~four_lane
                      & (width != 3'h4);
    assign hold_req = hold_allow & ~pin_s2.lane[3];

    // Change takes effect only while the bus clock is low; deselection clears it at once
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            held <= 1'b0;
        end else if (!selected) begin
            held <= 1'b0;
        end else if (held != hold_req && !pin_s2.clk) begin
            held <= hold_req;
        end
    end

    // ======================================================================
    // Opcode capture and decode
    // ======================================================================
    logic shift_en;
    logic [7:0] next_cmd_sh;
    logic [3:0] next_bit_cnt;
    logic cmd_done;
    logic [7:0] op;

    // Paused clock edges are ignored, shift state is kept
    assign shift_en = sclk_rise & ~held & (frame == sfb_pkg::FR_CMD);
    assign next_cmd_sh = four_lane ? {cmd_sh[3:0], pin_s2.lane}
                                   : {cmd_sh[6:0], pin_s2.lane[0]};
    assign next_bit_cnt = bit_cnt + (four_lane ? 4'h4 : 4'h1);
    assign cmd_done = shift_en & (next_bit_cnt == 4'h8);
    assign op = next_cmd_sh;

    logic is_write;
    logic is_dual;
    logic is_quad;
    logic is_read;
    logic ignore_all;
    logic sr_locked;
    logic wr_ok;
    logic accept_wr;
    logic accept_wren;
    logic reject;

    // Classify the opcode just completed
    always_comb begin
        is_write = 1'b0;
        is_dual = 1'b0;
        is_quad = 1'b0;
        is_read = 1'b0;
        case (op)
            `SFB_OP_PP, `SFB_OP_QPP, `SFB_OP_SE, `SFB_OP_BE32,
            `SFB_OP_BE64, `SFB_OP_CE, `SFB_OP_WRSR: is_write = 1'b1;
            `SFB_OP_DOUT, `SFB_OP_DIO: is_dual = 1'b1;
            `SFB_OP_QOUT, `SFB_OP_QIO, `SFB_OP_QWRD, `SFB_OP_QOCT: is_quad = 1'b1;
            `SFB_OP_READ, `SFB_OP_FREAD: is_read = 1'b1;
            default: is_read = 1'b0;
        endcase
    end

    // Power-down filters all but release
    assign ignore_all = pdown & (op != `SFB_OP_RPD);
    // Guard pin counts only while it is not serving as a lane
    assign sr_locked = lock1 | (lock0 & ~quad_lane_enable & ~pin_s2.lane[2]);
    assign wr_ok = wul & ~puw_lock & ~busy
                 & ((op != `SFB_OP_WRSR) | ~sr_locked);
    assign accept_wr = cmd_done & ~ignore_all & is_write & wr_ok;
    assign accept_wren = cmd_done & ~ignore_all & (op == `SFB_OP_WREN)
                       & ~puw_lock & ~busy;
    assign reject = cmd_done & ~ignore_all
                  & ((is_write & ~wr_ok)
                  | ((op == `SFB_OP_WREN) & ~accept_wren)
                  | (is_quad & ~quad_lane_enable)
                  | ((op == `SFB_OP_FLM_ON) & ~quad_lane_enable));

    // ======================================================================
    // Frame sequencing
    // ======================================================================
    // Select rise or deselection always ends the frame
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            frame <= sfb_pkg::FR_IDLE;
            bit_cnt <= 4'h0;
            cmd_sh <= 8'h00;
        end else if (!selected) begin
            frame <= sfb_pkg::FR_IDLE;
            bit_cnt <= 4'h0;
        end else begin
            case (frame)
                sfb_pkg::FR_IDLE: begin
                    if (cs_fall) begin
                        frame <= sfb_pkg::FR_CMD;
                        bit_cnt <= 4'h0;
                    end
                end
                sfb_pkg::FR_CMD: begin
                    if (shift_en) begin
                        cmd_sh <= next_cmd_sh;
                        bit_cnt <= next_bit_cnt;
                    end
                    if (cmd_done) begin
                        if (!ignore_all && ((op == `SFB_OP_RDSR) || is_read
                            || is_dual || (is_quad && quad_lane_enable))) begin
                            frame <= sfb_pkg::FR_SEND;
                        end else begin
                            frame <= sfb_pkg::FR_SKIP;
                        end
                    end
                end
                sfb_pkg::FR_SEND: frame <= sfb_pkg::FR_SEND;
                sfb_pkg::FR_SKIP: frame <= sfb_pkg::FR_SKIP;
                default: frame <= sfb_pkg::FR_IDLE;
            endcase
        end
    end

    // ======================================================================
    // Modes and power-down
    // ======================================================================
    // Four-lane command mode entry and exit
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            four_lane <= 1'b0;
        end else if (cmd_done && !ignore_all) begin
            if (op == `SFB_OP_FLM_ON && quad_lane_enable) begin
                four_lane <= 1'b1;
            end else if (op == `SFB_OP_FLM_OFF || op == `SFB_OP_SWRST) begin
                four_lane <= 1'b0;
            end
        end
    end

    // Power-down entry and release
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pdown <= 1'b0;
        end else if (cmd_done) begin
            if (op == `SFB_OP_RPD) begin
                pdown <= 1'b0;
            end else if (op == `SFB_OP_PDN && !pdown) begin
                pdown <= 1'b1;
            end
        end
    end

    // Lane width of the data phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            width <= 3'h1;
        end else if (!selected) begin
            width <= 3'h1;
        end else if (cmd_done) begin
            if (four_lane || (is_quad && quad_lane_enable)) begin
                width <= 3'h4;
            end else if (is_dual) begin
                width <= 3'h2;
            end else begin
                width <= 3'h1;
            end
        end
    end

    // ======================================================================
    // Write unlock latch and operation hand-off
    // ======================================================================
    // Set only by an accepted write enable; busy blocks it, so no overlap
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wul <= 1'b0;
        end else if (accept_wren) begin
            wul <= 1'b1;
        end else if (busy && op_done) begin
            wul <= 1'b0;
        end else if (cmd_done && !ignore_all
                     && (op == `SFB_OP_WRDI || op == `SFB_OP_SWRST)) begin
            wul <= 1'b0;
        end
    end

    // Array operation start and busy tracking
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            busy <= 1'b0;
            op_start <= 1'b0;
            op_code <= 8'h00;
        end else begin
            op_start <= accept_wr;
            if (accept_wr) begin
                busy <= 1'b1;
                op_code <= op;
            end else if (op_done) begin
                busy <= 1'b0;
            end
        end
    end

    // Last decoded opcode and refusal event, set wins over clear
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            last_op <= 8'h00;
            rej_evt <= 1'b0;
        end else begin
            if (cmd_done && !ignore_all) begin
                last_op <= op;
            end
            if (reject) begin
                rej_evt <= 1'b1;
            end else if (psel && penable && pwrite && paddr == `SFB_EVT_OFS
                         && pwdata[`SFB_EVT_REJ_BIT]) begin
                rej_evt <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Output shifting
    // ======================================================================
    logic [7:0] stat_byte;
    logic [3:0] oe_mask;

    assign stat_byte = {6'h00, wul, busy};
    assign oe_mask = (width == 3'h4) ? 4'hF : (width == 3'h2) ? 4'h3 : 4'h2;

    // Drive on falling clock; paused edges do nothing
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_sh <= 8'h00;
            tx_left <= 4'h0;
            tx_started <= 1'b0;
            tx_status <= 1'b0;
            lane_out <= 4'h0;
        end else if (!selected) begin
            tx_started <= 1'b0;
            tx_left <= 4'h0;
        end else if (cmd_done) begin
            tx_status <= (op == `SFB_OP_RDSR);
            tx_left <= 4'h0;
        end else if (frame == sfb_pkg::FR_SEND && sclk_fall && !held) begin
            tx_started <= 1'b1;
            if (width == 3'h4) begin
                lane_out <= (tx_left == 4'h0) ? (tx_status ? stat_byte[7:4] : rd_byte[7:4])
                                              : tx_sh[7:4];
            end else if (width == 3'h2) begin
                lane_out <= {2'b00, (tx_left == 4'h0)
                             ? (tx_status ? stat_byte[7:6] : rd_byte[7:6]) : tx_sh[7:6]};
            end else begin
                lane_out <= {2'b00, (tx_left == 4'h0)
                             ? (tx_status ? stat_byte[7] : rd_byte[7]) : tx_sh[7], 1'b0};
            end
            if (tx_left == 4'h0) begin
                tx_sh <= (tx_status ? stat_byte : rd_byte) << width;
                tx_left <= 4'h8 - {1'b0, width};
            end else begin
                tx_sh <= tx_sh << width;
                tx_left <= tx_left - {1'b0, width};
            end
        end
    end

    // Enables follow selection, send phase and pause
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            lane_oe <= 4'h0;
        end else if (selected && frame == sfb_pkg::FR_SEND && tx_started && !held) begin
            lane_oe <= oe_mask;
        end else begin
            lane_oe <= 4'h0;
        end
    end

    // ======================================================================
    // APB slave
    // ======================================================================
    logic acc_wr;
    logic setup;

    assign acc_wr = psel & penable & pwrite;
    assign setup = psel & ~penable;

    // Control register; quad enable cannot drop in four-lane mode
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `SFB_CTRL_RST;
        end else if (acc_wr && paddr == `SFB_CTRL_OFS) begin
            ctrl[`SFB_CTRL_SL0_BIT] <= pwdata[`SFB_CTRL_SL0_BIT];
            ctrl[`SFB_CTRL_SL1_BIT] <= pwdata[`SFB_CTRL_SL1_BIT];
            ctrl[`SFB_CTRL_QLE_BIT] <= pwdata[`SFB_CTRL_QLE_BIT] | four_lane;
        end
    end

    // Read data and error captured in the setup phase
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
                case (paddr)
                    `SFB_CTRL_OFS: prdata <= {29'h0, ctrl};
                    `SFB_STAT_OFS: prdata <= {16'h0, last_op, 1'b0, held, armed,
                                              puw_lock, pdown, four_lane, wul, busy};
                    `SFB_EVT_OFS: prdata <= {31'h0, rej_evt};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// [sfb_front_end_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sfb_params.svh"
// ==========
// Port checker
module sfb_fe_chk #(
    parameter int PUW_CYC = 16,
    parameter int AW = 12
) (
    input wire logic sys_clk, // Clock
    input wire logic resetn, // Reset
    input wire logic bus_clk, // Bus clock
    input wire logic bus_csn, // Select
    input wire logic [3:0] lane_in, // Lanes in
    input wire logic [3:0] lane_oe, // Lane enables
    input wire logic op_start, // Op pulse
    input wire logic [7:0] op_code, // Op code
    input wire logic psel, // Select
    input wire logic penable, // Enable
    input wire logic [AW-1:0] paddr, // Address
    input wire logic pready, // Ready
    input wire logic pslverr // Error
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    // Cycles since reset release
    int unsigned up_cnt;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            up_cnt <= 0;
        end else if (up_cnt < PUW_CYC) begin
            up_cnt <= up_cnt + 1;
        end
    end
    a_desel_quiet: assert property (bus_csn [*5] |-> lane_oe == 4'h0)
        else $error("lanes driven while deselected");
    a_puw_lock: assert property (op_start |-> up_cnt >= PUW_CYC)
        else $error("start inside power-up delay");
    a_start_code: assert property (op_start |-> op_code inside
        {`SFB_OP_PP, `SFB_OP_QPP, `SFB_OP_SE, `SFB_OP_BE32, `SFB_OP_BE64,
        `SFB_OP_CE, `SFB_OP_WRSR}) else $error("start of a non-write code");
    a_start_pulse: assert property (op_start |=> !op_start)
        else $error("start pulse too long");
    a_code_hold: assert property (!op_start |-> $stable(op_code))
        else $error("code moved without start");
    a_apb_err: assert property (psel && penable |-> pslverr == !(paddr inside
        {`SFB_CTRL_OFS, `SFB_STAT_OFS, `SFB_EVT_OFS})) else $error("bad error flag");
    a_zero_wait: assert property (psel && !penable |=> pready)
        else $error("access phase not ready");
    a_pause_quiet: assert property ((!bus_csn && !lane_in[3] && !bus_clk) [*8]
        |-> lane_oe inside {4'h0, 4'hF}) else $error("drive during pause");
    // Main scenarios
    c_start: cover property (op_start);
    c_quad: cover property (lane_oe == 4'hF);
    c_err: cover property (psel && penable && pslverr);
endmodule
bind sfb_front_end sfb_fe_chk #(.PUW_CYC(PUW_CYC), .AW(AW)) chk (.sys_clk, .resetn,
    .bus_clk, .bus_csn, .lane_in, .lane_oe, .op_start, .op_code, .psel, .penable,
    .paddr, .pready, .pslverr);
`default_nettype wire

// [sfb_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Host controller driving clock, select and lanes
module sfb_host_model (
    input wire logic [3:0] lane_out, // Device values
    input wire logic [3:0] lane_oe, // Device enables
    output wire sfb_pkg::sfb_pins_t pins // Pins at device
);
    logic bclk = 1'h0;
    logic csn = 1'h1; // Select high until first frame
    logic [3:0] drv = 4'hF;
    logic [3:0] drv_oe = 4'h0;
    logic [1:0] ctl_n = 2'h3;
    logic [3:0] oe_seen = 4'h0;
    logic [7:0] got = 8'h0;
    logic [3:0] lane;
    // Wire level: device, else host, else pull-up
    assign lane = (lane_oe & lane_out) | (~lane_oe & ((drv_oe & drv) | (~drv_oe & {ctl_n, 2'h3})));
    assign pins = {bclk, csn, lane};
    // Lanes the device drove in this frame
    always @(lane_oe) begin
        if (!csn) oe_seen = oe_seen | lane_oe;
    end
    // One selection: opcode, optional pause, read bits from lane 1
    task automatic frame(input logic [7:0] op, input logic q, m3, input int nrd, hat);
        int n;
        n = q ? 2 : 8;
        bclk = m3;
        oe_seen = 4'h0;
        #32 csn = 1'h0;
        for (int i = 0; i < n + nrd; i++) begin
            #32 bclk = 1'h0;
            if (i == hat) begin
                // Pause with clock low, clock toggled meanwhile, select kept low
                #16 ctl_n[1] = 1'h0;
                repeat (2) begin
                    #32 bclk = 1'h1;
                    #32 bclk = 1'h0;
                end
                #64 ctl_n[1] = 1'h1;
                #16;
            end
            drv_oe = (i >= n) ? 4'h0 : (q ? 4'hF : 4'h1);
            drv = q ? op[7-4*i -: 4] : {3'h7, op[7-i]};
            #32 bclk = 1'h1;
            if (i >= n) got = {got[6:0], lane[1]};
        end
        #32 bclk = m3;
        drv_oe = 4'h0;
        #32 csn = 1'h1;
    endtask
endmodule
`default_nettype wire

// [sfb_front_end_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sfb_params.svh"
module sfb_front_end_bench;
    localparam int PUW = 800;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic op_done = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, op_start, er;
    logic [7:0] op_code;
    logic [3:0] lane_out, lane_oe;
    sfb_pkg::sfb_pins_t pins;
    int error_cnt = 0, n_compared = 0, cyc = 0, starts = 0;
    // Rows: write, address, data or expected read, error
    logic [45:0] rows [6] = '{{1'h0, 12'h000, 32'h0, 1'h0}, {1'h1, 12'h000, 32'h7, 1'h0},
        {1'h0, 12'h000, 32'h7, 1'h0}, {1'h1, 12'h00C, 32'h1, 1'h1},
        {1'h0, 12'h00C, 32'h0, 1'h1}, {1'h1, 12'h000, 32'h0, 1'h0}};
    logic [11:0] rd_tab [6] = '{12'h3B3, 12'hBB3, 12'h6BF, 12'hEBF, 12'hE7F, 12'hE3F};
    logic [7:0] exits [2] = '{`SFB_OP_FLM_OFF, `SFB_OP_SWRST};
    sfb_front_end #(.PUW_CYC(PUW)) uut (.sys_clk, .resetn, .bus_clk(pins.clk),
        .bus_csn(pins.csn), .lane_in(pins.lane), .lane_out, .lane_oe, .rd_byte(8'h5A),
        .op_done, .op_start, .op_code, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    sfb_host_model host (.lane_out, .lane_oe, .pins);
    // ==========
    // Clock, ceiling and start count
    initial forever #2.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (op_start === 1'h1) starts <= starts + 1;
        if (cyc == 30000) begin
            error_cnt = error_cnt + 1;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] g, e, input string s);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask
    // One register transfer
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge sys_clk) penable <= 1'h1;
        do @(posedge sys_clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, e);
        apb(1'h0, a, 32'h0);
        check(rd & m, e, "register");
    endtask
    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ==========
    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        check({28'h0, lane_oe}, 32'h0, "reset lanes");
        resetn <= 1'h1;
        foreach (rows[k]) begin
            apb(rows[k][45], rows[k][44:33], rows[k][32:1]);
            check({31'h0, er}, {31'h0, rows[k][0]}, "error flag");
            if (!rows[k][45]) check(rd, rows[k][32:1], "read data");
        end
        host.frame(`SFB_OP_WREN, 0, 0, 0, -1);
        host.frame(`SFB_OP_SE, 0, 0, 0, -1);
        rdchk(`SFB_EVT_OFS, 32'h1, 32'h1);
        rdchk(`SFB_STAT_OFS, 32'h12, 32'h10);
        apb(1'h1, `SFB_EVT_OFS, 32'h1);
        repeat (PUW) @(posedge sys_clk);
        host.frame(`SFB_OP_SE, 0, 0, 0, -1);
        rdchk(`SFB_EVT_OFS, 32'h1, 32'h1);
        host.frame(`SFB_OP_WREN, 0, 0, 0, -1);
        host.frame(`SFB_OP_RDSR, 0, 1, 8, 3);
        check({24'h0, host.got}, 32'h2, "status byte");
        check({28'h0, host.oe_seen}, 32'h2, "single lane");
        host.frame(`SFB_OP_SE, 0, 0, 0, -1);
        check(starts, 32'h1, "starts");
        check({24'h0, op_code}, {24'h0, `SFB_OP_SE}, "op code");
        rdchk(`SFB_STAT_OFS, 32'h3, 32'h3);
        @(posedge sys_clk) op_done <= 1'h1;
        @(posedge sys_clk) op_done <= 1'h0;
        rdchk(`SFB_STAT_OFS, 32'h3, 32'h0);
        apb(1'h1, `SFB_CTRL_OFS, 32'h2);
        apb(1'h1, `SFB_EVT_OFS, 32'h1);
        host.ctl_n[0] <= 1'h0;
        host.frame(`SFB_OP_WREN, 0, 0, 0, -1);
        host.frame(`SFB_OP_WRSR, 0, 0, 0, -1);
        check(starts, 32'h1, "guarded write");
        rdchk(`SFB_EVT_OFS, 32'h1, 32'h1);
        host.ctl_n[0] <= 1'h1;
        apb(1'h1, `SFB_CTRL_OFS, 32'h0);
        host.frame(`SFB_OP_PDN, 0, 0, 0, -1);
        host.frame(`SFB_OP_WRDI, 0, 0, 0, -1);
        rdchk(`SFB_STAT_OFS, 32'hA, 32'hA);
        host.frame(`SFB_OP_RPD, 0, 0, 0, -1);
        host.frame(`SFB_OP_WRDI, 0, 0, 0, -1);
        rdchk(`SFB_STAT_OFS, 32'hA, 32'h0);
        host.frame(`SFB_OP_FLM_ON, 0, 0, 0, -1);
        rdchk(`SFB_STAT_OFS, 32'h4, 32'h0);
        host.frame(`SFB_OP_QOUT, 0, 0, 8, -1);
        check({28'h0, host.oe_seen}, 32'h0, "quad refused");
        apb(1'h1, `SFB_CTRL_OFS, 32'h1);
        foreach (exits[k]) begin
            host.frame(`SFB_OP_FLM_ON, 0, 0, 0, -1);
            rdchk(`SFB_STAT_OFS, 32'h4, 32'h4);
            host.frame(exits[k], 1, 0, 0, -1);
            rdchk(`SFB_STAT_OFS, 32'h4, 32'h0);
        end
        foreach (rd_tab[k]) begin
            host.frame(rd_tab[k][11:4], 0, 0, 8, -1);
            check({28'h0, host.oe_seen}, {28'h0, rd_tab[k][3:0]}, "lanes");
        end
        complete_run();
    end
endmodule
`default_nettype wire
